// ### logic/fic_mon_link.sv
`timescale 1ns/10ps
`default_nettype none
module fic_mon_link #(
  parameter int unsigned DIV = fic_pkg::BAUD_DIV
) (
  input  wire logic       ref_clk_i,   // system clock
  input  wire logic       resetn_i,    // async reset, active low
  input  wire logic       enable_i,    // monitor mode active
  input  wire logic [7:0] tx_data_i,   // byte to send
  input  wire logic       tx_valid_i,  // send request
  output logic            tx_ready_o,  // link idle, byte accepted
  output logic [7:0]      rx_data_o,   // received byte
  output logic            rx_valid_o,  // one-cycle receive strobe
  input  wire logic       pin_i,       // serial pin level
  output logic            pin_o,       // serial pin drive level
  output logic            pin_oe_o     // serial pin drive enable
);

  if (DIV < 4 || DIV > 65535) begin : g_div_chk
    $error("baud divisor out of range");
  end

  localparam logic [15:0] DIV_M1  = 16'(DIV - 1);
  localparam logic [15:0] HALF_M1 = 16'(DIV / 2 - 1);
  localparam logic [3:0]  DATA_END = 4'h8;
  localparam logic [3:0]  STOP_END = 4'h9;

  fic_pkg::fic_link_t state, next_state;
  logic [15:0] div_cnt, next_div_cnt;
  logic [3:0]  bit_idx, next_bit_idx;
  logic [7:0]  shreg, next_shreg;
  logic [7:0]  next_rx_data;
  logic        next_rx_valid, next_tx_ready, next_pin, next_pin_oe;

  always_comb begin
    next_state    = state;
    next_div_cnt  = div_cnt;
    next_bit_idx  = bit_idx;
    next_shreg    = shreg;
    next_rx_data  = rx_data_o;
    next_rx_valid = 1'b0;
    next_tx_ready = tx_ready_o;
    next_pin      = pin_o;
    next_pin_oe   = pin_oe_o;
    unique case (state)
      fic_pkg::LK_IDLE: begin
        next_pin_oe   = 1'b0;
        next_tx_ready = enable_i;
        if (enable_i && tx_valid_i && tx_ready_o) begin
          next_shreg    = tx_data_i;
          next_pin      = 1'b0;
          next_pin_oe   = 1'b1;
          next_div_cnt  = DIV_M1;
          next_bit_idx  = '0;
          next_tx_ready = 1'b0;
          next_state    = fic_pkg::LK_TX;
        end else if (enable_i && !pin_i) begin
          next_div_cnt  = HALF_M1;
          next_bit_idx  = '0;
          next_tx_ready = 1'b0;
          next_state    = fic_pkg::LK_RX;
        end
      end
      fic_pkg::LK_TX: begin
        if (div_cnt != '0) begin
          next_div_cnt = div_cnt - 16'h0001;
        end else begin
          next_div_cnt = DIV_M1;
          next_bit_idx = bit_idx + 4'h1;
          if (bit_idx < DATA_END) begin
            next_pin   = shreg[0];
            next_shreg = {1'b0, shreg[7:1]};
          end else if (bit_idx == DATA_END) begin
            next_pin = 1'b1;
          end else begin
            next_pin_oe   = 1'b0;
            next_tx_ready = enable_i;
            next_state    = fic_pkg::LK_IDLE;
          end
        end
      end
      fic_pkg::LK_RX: begin
        if (div_cnt != '0) begin
          next_div_cnt = div_cnt - 16'h0001;
        end else begin
          next_div_cnt = DIV_M1;
          next_bit_idx = bit_idx + 4'h1;
          if (bit_idx == '0 && pin_i) begin
            next_state = fic_pkg::LK_IDLE;  // glitch, not a start bit
          end else if (bit_idx != '0 && bit_idx <= DATA_END) begin
            next_shreg = {pin_i, shreg[7:1]};
          end else if (bit_idx == STOP_END) begin
            next_rx_valid = pin_i;  // framing error drops the byte
            next_rx_data  = shreg;
            next_state    = fic_pkg::LK_IDLE;
          end
        end
      end
    endcase
    if (!enable_i) begin
      next_state    = fic_pkg::LK_IDLE;
      next_pin_oe   = 1'b0;
      next_tx_ready = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state      <= fic_pkg::LK_IDLE;
      div_cnt    <= '0;
      bit_idx    <= '0;
      shreg      <= '0;
      rx_data_o  <= '0;
      rx_valid_o <= 1'b0;
      tx_ready_o <= 1'b0;
      pin_o      <= 1'b1;
      pin_oe_o   <= 1'b0;
    end else begin
      state      <= next_state;
      div_cnt    <= next_div_cnt;
      bit_idx    <= next_bit_idx;
      shreg      <= next_shreg;
      rx_data_o  <= next_rx_data;
      rx_valid_o <= next_rx_valid;
      tx_ready_o <= next_tx_ready;
      pin_o      <= next_pin;
      pin_oe_o   <= next_pin_oe;
    end
  end

  a_link_quiet_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !enable_i |=> !pin_oe_o)
    else $error("serial pin driven outside monitor mode");

endmodule
`default_nettype wire

// ### logic/fic_pkg.sv
`default_nettype none
package fic_pkg;

  // reset vector and the erased byte value
  localparam logic [15:0] VEC_HI_ADDR    = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR    = 16'hFFFF;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

  // erase preparation writes
  localparam logic [15:0] PROT_REG_ADDR  = 16'hFE09;
  localparam logic [7:0]  PROT_ALL_OFF   = 8'hFF;
  localparam logic [15:0] CTRL_BYTE_ADDR = 16'h0088;
  localparam logic [15:0] SPEED_BYTE_ADDR = 16'h0089;
  localparam logic [7:0]  MASS_ERASE_CTRL = 8'h40;
  localparam logic [7:0]  BUS_SPEED_CODE = 8'h0A;

  // read-back of vectors and security bytes: base plus index 10 down to 1
  localparam logic [15:0] CHECK_BASE     = 16'hFFF6;
  localparam logic [3:0]  CHECK_COUNT    = 4'hA;
  localparam logic [3:0]  CHECK_LAST     = 4'h1;

  // clocks and rates
  localparam int unsigned REF_CLK_HZ     = 32'h0098_9680;
  localparam int unsigned BUS_REF_HZ     = 32'h0025_8000;
  localparam int unsigned XTAL_HZ        = 32'h0096_0000;
  localparam int unsigned MON_BAUD       = 32'h0000_2580;
  localparam int unsigned BAUD_DIV       = REF_CLK_HZ / MON_BAUD;

  // whole mass erase budget, in seconds
  localparam int unsigned ERASE_LIMIT_S  = 32'h0000_0002;
  localparam int unsigned ERASE_LIMIT_CYC = ERASE_LIMIT_S * REF_CLK_HZ;

  // erase pulse length in bus cycles at BUS_REF_HZ (plain default)
  localparam int unsigned ERASE_BUS_CYC  = 32'h0000_1000;

  typedef enum logic [14:0] {
    ST_VEC_HI   = 15'h0001,
    ST_VEC_LO   = 15'h0002,
    ST_VEC_CAP  = 15'h0004,
    ST_DECIDE   = 15'h0008,
    ST_MONITOR  = 15'h0010,
    ST_USER     = 15'h0020,
    ST_UNPROT   = 15'h0040,
    ST_CTRL     = 15'h0080,
    ST_SPEED    = 15'h0100,
    ST_ERASE    = 15'h0200,
    ST_CHK_RD   = 15'h0400,
    ST_CHK_WAIT = 15'h0800,
    ST_CHK_CMP  = 15'h1000,
    ST_HALT     = 15'h2000,
    ST_FAIL     = 15'h4000
  } fic_state_t;

  typedef enum logic [2:0] {
    LK_IDLE = 3'h1,
    LK_RX   = 3'h2,
    LK_TX   = 3'h4
  } fic_link_t;

endpackage
`default_nettype wire

// ### logic/fic_top.sv
// Summary of operation
// - blank reset vector after reset selects monitor mode, no high voltage needed
// - high voltage on mode pin at reset also selects monitor mode
// - in user mode, strap high=1 and strap low=0 requests mass erase
// - write control and speed bytes into RAM before starting erase
// - repeat erase until vector and security bytes read erased
// - whole mass erase, repeats included, ends within two seconds
// - erase delays counted for 2.4576 MHz bus, rescaled to our clock
// - in monitor mode strap high pin is the two-way serial line
// - programmer uses device reset to synchronize before monitor traffic
// - monitor serial runs at 9600 baud
// - erase always covers the whole array, no partial ranges
// - unprotect all blocks by writing all ones to protection register
// - control byte 01000000 selects mass erase, speed byte is 10
`timescale 1ns/10ps
`default_nettype none
module fic_top #(
  parameter int unsigned ERASE_BUS_CYC = fic_pkg::ERASE_BUS_CYC,  // erase pulse, bus cycles
  parameter int unsigned TIMEOUT_CYC   = fic_pkg::ERASE_LIMIT_CYC // erase budget, ref cycles
) (
  input  wire logic        ref_clk_i,                  // 10 MHz clock
  input  wire logic        resetn_i,                   // async reset, active low
  input  wire logic        high_voltage_mode_pin_i,    // high voltage detected on mode pin
  input  wire logic        strap_high_serial_pin_i,    // strap / serial pin level
  output logic             strap_high_serial_pin_o,    // serial pin drive level
  output logic             strap_high_serial_pin_oe_o, // serial pin drive enable
  input  wire logic        strap_low_pin_i,            // second strap pin
  input  wire logic [7:0]  flash_rdata_i,              // flash read data
  output logic [15:0]      flash_addr_o,               // flash read address
  output logic             flash_rd_o,                 // flash read strobe
  output logic [15:0]      bus_addr_o,                 // internal write address
  output logic [7:0]       bus_wdata_o,                // internal write data
  output logic             bus_wr_o,                   // internal write strobe
  output logic             flash_erase_o,              // erase pulse to array
  output logic             flash_mass_o,               // whole-array select
  output logic             monitor_mode_o,             // monitor mode selected
  output logic             user_mode_o,                // user mode selected
  output logic [15:0]      user_pc_o,                  // fetched reset vector
  output logic             erase_busy_o,               // mass erase running
  output logic             erase_ok_o,                 // mass erase verified
  output logic             erase_fail_o,               // erase budget exceeded
  input  wire logic [7:0]  mon_tx_data_i,              // monitor byte to send
  input  wire logic        mon_tx_valid_i,             // monitor send request
  output logic             mon_tx_ready_o,             // monitor link ready
  output logic [7:0]       mon_rx_data_o,              // monitor received byte
  output logic             mon_rx_valid_o              // monitor receive strobe
);

  if (ERASE_BUS_CYC == 0 || TIMEOUT_CYC < 2) begin : g_par_chk
    $error("erase timing parameters out of range");
  end

  // rescale bus-clock delays to the reference clock, rounding up
  localparam longint unsigned ERASE_CYC_L =
    (longint'(ERASE_BUS_CYC) * fic_pkg::REF_CLK_HZ + fic_pkg::BUS_REF_HZ - 1)
    / fic_pkg::BUS_REF_HZ;
  localparam logic [31:0] ERASE_CYC = 32'(ERASE_CYC_L);
  localparam logic [31:0] LIMIT_M1  = 32'(TIMEOUT_CYC - 1);

  function automatic logic is_erased(input logic [7:0] b);
    return b == fic_pkg::ERASED_BYTE;
  endfunction

  fic_pkg::fic_state_t state, next_state;
  logic [7:0]  vec_hi, next_vec_hi;
  logic [3:0]  chk_idx, next_chk_idx;
  logic [31:0] erase_cnt, next_erase_cnt;
  logic [31:0] limit_cnt, next_limit_cnt;
  logic [15:0] next_flash_addr, next_bus_addr, next_user_pc;
  logic [7:0]  next_bus_wdata;
  logic        next_flash_rd, next_bus_wr, next_flash_erase, next_flash_mass;
  logic        next_monitor, next_user, next_busy, next_ok, next_fail;
  logic        vec_blank, erase_req;

  assign vec_blank = is_erased(vec_hi) && is_erased(flash_rdata_i);
  assign erase_req = strap_high_serial_pin_i && !strap_low_pin_i;

  always_comb begin
    next_state       = state;
    next_vec_hi      = vec_hi;
    next_chk_idx     = chk_idx;
    next_erase_cnt   = erase_cnt;
    next_limit_cnt   = limit_cnt;
    next_flash_addr  = flash_addr_o;
    next_flash_rd    = 1'b0;
    next_bus_addr    = bus_addr_o;
    next_bus_wdata   = bus_wdata_o;
    next_bus_wr      = 1'b0;
    next_flash_erase = flash_erase_o;
    next_flash_mass  = flash_mass_o;
    next_monitor     = monitor_mode_o;
    next_user        = user_mode_o;
    next_user_pc     = user_pc_o;
    next_busy        = erase_busy_o;
    next_ok          = erase_ok_o;
    next_fail        = erase_fail_o;
    unique case (state)
      fic_pkg::ST_VEC_HI: begin
        next_flash_addr = fic_pkg::VEC_HI_ADDR;
        next_flash_rd   = 1'b1;
        next_state      = fic_pkg::ST_VEC_LO;
      end
      fic_pkg::ST_VEC_LO: begin
        next_flash_addr = fic_pkg::VEC_LO_ADDR;
        next_flash_rd   = 1'b1;
        next_state      = fic_pkg::ST_VEC_CAP;
      end
      fic_pkg::ST_VEC_CAP: begin
        next_vec_hi = flash_rdata_i;
        next_state  = fic_pkg::ST_DECIDE;
      end
      fic_pkg::ST_DECIDE: begin
        if (vec_blank || high_voltage_mode_pin_i) begin
          next_monitor = 1'b1;
          next_state   = fic_pkg::ST_MONITOR;
        end else if (erase_req) begin
          next_busy      = 1'b1;
          next_limit_cnt = '0;
          next_state     = fic_pkg::ST_UNPROT;
        end else begin
          next_user    = 1'b1;
          next_user_pc = {vec_hi, flash_rdata_i};
          next_state   = fic_pkg::ST_USER;
        end
      end
      fic_pkg::ST_UNPROT: begin
        next_bus_addr  = fic_pkg::PROT_REG_ADDR;
        next_bus_wdata = fic_pkg::PROT_ALL_OFF;
        next_bus_wr    = 1'b1;
        next_state     = fic_pkg::ST_CTRL;
      end
      fic_pkg::ST_CTRL: begin
        next_bus_addr  = fic_pkg::CTRL_BYTE_ADDR;
        next_bus_wdata = fic_pkg::MASS_ERASE_CTRL;
        next_bus_wr    = 1'b1;
        next_state     = fic_pkg::ST_SPEED;
      end
      fic_pkg::ST_SPEED: begin
        next_bus_addr  = fic_pkg::SPEED_BYTE_ADDR;
        next_bus_wdata = fic_pkg::BUS_SPEED_CODE;
        next_bus_wr    = 1'b1;
        next_state     = fic_pkg::ST_ERASE;
      end
      fic_pkg::ST_ERASE: begin
        // first cycle here raises the pulse, held ERASE_CYC cycles
        if (!flash_erase_o) begin
          next_flash_erase = 1'b1;
          next_flash_mass  = 1'b1;
          next_erase_cnt   = ERASE_CYC - 32'h0000_0001;
        end else if (erase_cnt != '0) begin
          next_erase_cnt = erase_cnt - 32'h0000_0001;
        end else begin
          next_flash_erase = 1'b0;
          next_flash_mass  = 1'b0;
          next_chk_idx     = fic_pkg::CHECK_COUNT;
          next_state       = fic_pkg::ST_CHK_RD;
        end
      end
      fic_pkg::ST_CHK_RD: begin
        next_flash_addr = fic_pkg::CHECK_BASE + {12'h000, chk_idx};
        next_flash_rd   = 1'b1;
        next_state      = fic_pkg::ST_CHK_WAIT;
      end
      fic_pkg::ST_CHK_WAIT: begin
        next_state = fic_pkg::ST_CHK_CMP;
      end
      fic_pkg::ST_CHK_CMP: begin
        if (!is_erased(flash_rdata_i)) begin
          next_state = fic_pkg::ST_UNPROT;
        end else if (chk_idx == fic_pkg::CHECK_LAST) begin
          next_busy  = 1'b0;
          next_ok    = 1'b1;
          next_state = fic_pkg::ST_HALT;
        end else begin
          next_chk_idx = chk_idx - 4'h1;
          next_state   = fic_pkg::ST_CHK_RD;
        end
      end
      // terminal states: only a new reset leaves them
      fic_pkg::ST_MONITOR, fic_pkg::ST_USER, fic_pkg::ST_HALT, fic_pkg::ST_FAIL: begin
        next_state = state;
      end
    endcase
    if (erase_busy_o) begin
      next_limit_cnt = limit_cnt + 32'h0000_0001;
      // a stuck array must not loop forever past the budget
      if (limit_cnt == LIMIT_M1 && next_busy) begin
        next_busy        = 1'b0;
        next_fail        = 1'b1;
        next_flash_erase = 1'b0;
        next_flash_mass  = 1'b0;
        next_state       = fic_pkg::ST_FAIL;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state          <= fic_pkg::ST_VEC_HI;
      vec_hi         <= '0;
      chk_idx        <= '0;
      erase_cnt      <= '0;
      limit_cnt      <= '0;
      flash_addr_o   <= '0;
      flash_rd_o     <= 1'b0;
      bus_addr_o     <= '0;
      bus_wdata_o    <= '0;
      bus_wr_o       <= 1'b0;
      flash_erase_o  <= 1'b0;
      flash_mass_o   <= 1'b0;
      monitor_mode_o <= 1'b0;
      user_mode_o    <= 1'b0;
      user_pc_o      <= '0;
      erase_busy_o   <= 1'b0;
      erase_ok_o     <= 1'b0;
      erase_fail_o   <= 1'b0;
    end else begin
      state          <= next_state;
      vec_hi         <= next_vec_hi;
      chk_idx        <= next_chk_idx;
      erase_cnt      <= next_erase_cnt;
      limit_cnt      <= next_limit_cnt;
      flash_addr_o   <= next_flash_addr;
      flash_rd_o     <= next_flash_rd;
      bus_addr_o     <= next_bus_addr;
      bus_wdata_o    <= next_bus_wdata;
      bus_wr_o       <= next_bus_wr;
      flash_erase_o  <= next_flash_erase;
      flash_mass_o   <= next_flash_mass;
      monitor_mode_o <= next_monitor;
      user_mode_o    <= next_user;
      user_pc_o      <= next_user_pc;
      erase_busy_o   <= next_busy;
      erase_ok_o     <= next_ok;
      erase_fail_o   <= next_fail;
    end
  end

  // link only runs once monitor mode is chosen, so each reset realigns it
  fic_mon_link #(
    .DIV (fic_pkg::BAUD_DIV)
  ) u_link (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .enable_i   (monitor_mode_o),
    .tx_data_i  (mon_tx_data_i),
    .tx_valid_i (mon_tx_valid_i),
    .tx_ready_o (mon_tx_ready_o),
    .rx_data_o  (mon_rx_data_o),
    .rx_valid_o (mon_rx_valid_o),
    .pin_i      (strap_high_serial_pin_i),
    .pin_o      (strap_high_serial_pin_o),
    .pin_oe_o   (strap_high_serial_pin_oe_o)
  );

  // helper: length of the current erase pulse
  logic [31:0] pulse_len;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_len <= '0;
    end else begin
      pulse_len <= flash_erase_o ? pulse_len + 32'h0000_0001 : '0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_prep;
    bus_wr_o && bus_addr_o == fic_pkg::PROT_REG_ADDR && bus_wdata_o == fic_pkg::PROT_ALL_OFF
    ##1 bus_wr_o && bus_addr_o == fic_pkg::CTRL_BYTE_ADDR
        && bus_wdata_o == fic_pkg::MASS_ERASE_CTRL
    ##1 bus_wr_o && bus_addr_o == fic_pkg::SPEED_BYTE_ADDR
        && bus_wdata_o == fic_pkg::BUS_SPEED_CODE;
  endsequence

  sequence s_decide_plain;
    state == fic_pkg::ST_DECIDE && !vec_blank && !high_voltage_mode_pin_i;
  endsequence

  a_blank_monitor: assert property (state == fic_pkg::ST_DECIDE && vec_blank
    |=> monitor_mode_o && !user_mode_o && !erase_busy_o)
    else $error("blank vector did not select monitor mode");
  a_hv_monitor: assert property (state == fic_pkg::ST_DECIDE && high_voltage_mode_pin_i
    |=> monitor_mode_o)
    else $error("high voltage did not select monitor mode");
  a_user_vector: assert property (s_decide_plain ##0 !erase_req
    |=> user_mode_o && user_pc_o == {$past(vec_hi), $past(flash_rdata_i)})
    else $error("user vector not loaded");
  a_strap_erase: assert property (s_decide_plain ##0 erase_req
    |=> erase_busy_o && !user_mode_o ##1 s_prep)
    else $error("strap pattern did not start erase");
  a_prep_order: assert property (state == fic_pkg::ST_UNPROT && !$past(erase_fail_o)
    |=> s_prep ##2 flash_erase_o && flash_mass_o)
    else $error("erase started without preparation writes");
  a_pulse_length: assert property ($fell(flash_erase_o) && !erase_fail_o
    |-> pulse_len == ERASE_CYC)
    else $error("erase pulse length wrong");
  a_dirty_repeat: assert property (state == fic_pkg::ST_CHK_CMP
    && !is_erased(flash_rdata_i) && limit_cnt != LIMIT_M1 |=> state == fic_pkg::ST_UNPROT)
    else $error("unerased byte did not repeat erase");
  a_erase_budget: assert property (erase_busy_o |-> limit_cnt < TIMEOUT_CYC)
    else $error("mass erase ran past its budget");
  a_mass_only: assert property (flash_erase_o |-> flash_mass_o)
    else $error("erase without whole-array select");
  a_pin_user_quiet: assert property (!monitor_mode_o |-> !strap_high_serial_pin_oe_o)
    else $error("serial pin driven outside monitor mode");

endmodule
`default_nettype wire

// ### verification/fic_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fic_flash_model (
  input  wire logic        clk_i,   // bus clock
  input  wire logic        clr_i,   // reload array image
  input  wire logic        rd_i,    // read strobe
  input  wire logic [15:0] addr_i,  // read address
  input  wire logic        erase_i, // erase pulse
  input  wire logic [15:0] vec_i,   // programmed reset vector
  input  wire logic [7:0]  bad_i,   // erase passes leaving one byte dirty
  output logic      [7:0]  rdata_o  // data in the cycle after the strobe
);
  logic [7:0] passes;
  logic       erase_q;
  always @(posedge clk_i) begin
    erase_q <= erase_i;
    if (clr_i) begin
      passes  <= 8'h00;
      rdata_o <= 8'h00;
    end else begin
      if (erase_q && !erase_i) passes <= passes + 8'h01;
      // released bus toggles so a stale byte is never mistaken for data
      if (!rd_i) rdata_o <= ~rdata_o;
      else if (addr_i == 16'hFFF8 && passes != 8'h00 && passes <= bad_i) rdata_o <= 8'h00;
      else if (passes != 8'h00) rdata_o <= 8'hFF;
      else if (addr_i == 16'hFFFE) rdata_o <= vec_i[15:8];
      else if (addr_i == 16'hFFFF) rdata_o <= vec_i[7:0];
      else rdata_o <= 8'hFF;
    end
  end
endmodule
`default_nettype wire

// ### verification/fic_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fic_top_tb;
  localparam int unsigned ECYC = 17; // ceil(4 * 10e6 / 2457600)
  localparam int unsigned BITC = fic_pkg::BAUD_DIV;
  logic clk = 1'b0, resetn = 1'b0, hv = 1'b0, ser = 1'b1, slow = 1'b1, txv = 1'b0;
  logic [7:0]  txd = 8'h00, rdat, rxd, bwd;
  logic [15:0] vec = 16'hFFFF, faddr, baddr, pc;
  logic [7:0]  bad = 8'h00;
  logic pin_o, pin_oe, frd, wr, ers, mass, mon, usr, busy, ok, fl, txr, rxv;
  wire logic pin = pin_oe ? pin_o : ser;
  logic [23:0] wq[$];
  int lq[$];
  int elen = 0, nomass = 0, rxn = 0, cyc = 0, fails = 0, checks = 0;
  logic [7:0] rxq;
  always #50 clk = ~clk;
  fic_top #(.ERASE_BUS_CYC(4), .TIMEOUT_CYC(2000)) DUT (.ref_clk_i(clk), .resetn_i(resetn),
    .high_voltage_mode_pin_i(hv), .strap_high_serial_pin_i(pin),
    .strap_high_serial_pin_o(pin_o), .strap_high_serial_pin_oe_o(pin_oe),
    .strap_low_pin_i(slow), .flash_rdata_i(rdat), .flash_addr_o(faddr), .flash_rd_o(frd),
    .bus_addr_o(baddr), .bus_wdata_o(bwd), .bus_wr_o(wr), .flash_erase_o(ers),
    .flash_mass_o(mass), .monitor_mode_o(mon), .user_mode_o(usr), .user_pc_o(pc),
    .erase_busy_o(busy), .erase_ok_o(ok), .erase_fail_o(fl), .mon_tx_data_i(txd),
    .mon_tx_valid_i(txv), .mon_tx_ready_o(txr), .mon_rx_data_o(rxd), .mon_rx_valid_o(rxv));
  fic_flash_model flash (.clk_i(clk), .clr_i(!resetn), .rd_i(frd), .addr_i(faddr),
    .erase_i(ers), .vec_i(vec), .bad_i(bad), .rdata_o(rdat));
  always @(posedge clk) begin
    cyc++;
    if (wr) wq.push_back({baddr, bwd});
    if (rxv) begin
      rxn++;
      rxq = rxd;
    end
    if (ers) begin
      elen++;
      if (!mass) nomass++;
    end else if (elen != 0) begin
      lq.push_back(elen);
      elen = 0;
    end
    if (cyc == 40000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // reset re-arms mode selection, as the programmer does to sync up
  task automatic boot(input logic [15:0] v, input logic h, s, l, input logic [7:0] b);
    @(negedge clk);
    {vec, hv, ser, slow, bad, resetn} = {v, h, s, l, b, 1'b0};
    repeat (8) @(negedge clk);
    wq.delete();
    lq.delete();
    nomass = 0;
    resetn = 1'b1;
    repeat (10) @(negedge clk);
  endtask
  task automatic t_modes();
    boot(16'hFFFF, 1'b0, 1'b1, 1'b0, 8'h00);
    chk("blank_mon", 2'b10, {mon, busy});
    boot(16'hEC00, 1'b1, 1'b1, 1'b0, 8'h00);
    chk("hv_mon", 3'b100, {mon, usr, busy});
    // straps 00, 01, 11: every pattern except the erase request
    for (int k = 0; k < 3; k++) begin
      boot(16'hEC00, 1'b0, k[1], k[0] | k[1], 8'h00);
      chk("user_pc", {3'b010, 16'hEC00}, {mon, usr, busy, pc});
    end
    $display("test modes done");
  endtask
  task automatic t_erase(input logic [7:0] b, input int np);
    boot(16'hEC00, 1'b0, 1'b1, 1'b0, b);
    for (int n = 0; n < 2500 && !ok && !fl; n++) @(negedge clk);
    chk("ok_fail_busy", (np > 0) ? 3'b100 : 3'b010, {ok, fl, busy});
    chk("mass_sel", 0, nomass);
    if (np > 0) begin
      chk("writes", 3 * np, wq.size());
      chk("pulses", np, lq.size());
      foreach (wq[n]) chk("wr0", {fic_pkg::PROT_REG_ADDR, 8'hFF}, wq[n - n % 3]);
      foreach (wq[n]) chk("wr1", {16'h0088, 8'h40}, wq[n - n % 3 + 1]);
      foreach (wq[n]) chk("wr2", {16'h0089, 8'h0A}, wq[n - n % 3 + 2]);
      foreach (lq[n]) chk("pulse_len", ECYC, lq[n]);
    end
    $display("test erase %0d done", b);
  endtask
  task automatic t_serial();
    boot(16'hFFFF, 1'b0, 1'b1, 1'b1, 8'h00);
    for (int n = 0; n < 20 && !txr; n++) @(negedge clk);
    {txd, txv} = {8'hA5, 1'b1};
    @(negedge clk);
    txv = 1'b0;
    repeat (BITC / 2) @(negedge clk);
    chk("start", 2'b10, {pin_oe, pin});
    for (int i = 0; i < 9; i++) begin
      repeat (BITC) @(negedge clk);
      chk("tx_bit", (i < 8) ? txd[i] : 1'b1, pin);
    end
    for (int n = 0; n < 2000 && !txr; n++) @(negedge clk);
    chk("oe_off", 0, pin_oe);
    for (int i = 0; i < 10; i++) begin
      ser = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : 1'(8'h3C >> (i - 1));
      repeat (BITC) @(negedge clk);
    end
    chk("rx", {8'h01, 8'h3C}, {rxn[7:0], rxq});
    $display("test serial done");
  endtask
  initial begin
    t_modes();
    t_erase(8'h01, 2);
    t_erase(8'hC8, 0);
    t_serial();
    end_sim();
  end
endmodule
`default_nettype wire
